// ### ppih_top.sv
// top of the dual parallel port adapter: registers, ports, two sides
// assumes one-cycle rd/wr strobes synchronous to clk, never both at once
//
// Contract
// RQ1 - b flags set by active edges
// RQ2 - port b data read clears b flags
// RQ3 - a irq low on enabled set flag
// RQ4 - b irq low on enabled set flag
// RQ5 - direction bit one means output
// RQ6 - port b input lines undriven
// RQ7 - a edge input polarity by bit 1
// RQ8 - bit 7 sets regardless of enable
// RQ9 - bit 6 sets regardless of enable
// RQ10 - a line input, polarity by bit 4
// RQ11 - a pulse on port a read
// RQ12 - pulse low exactly one cycle
// RQ13 - a handshake low after a read
// RQ14 - a handshake high on edge input
// RQ15 - manual output follows bit 3
// RQ16 - b edge input like a
// RQ17 - b line input like a
// RQ18 - b pulse on port b write
// RQ19 - b handshake governs outbound data
// RQ20 - b handshake low write, high edge
// RQ21 - port a data read clears a flags
// RQ22 - inputs synchronised, samples compared
// RQ23 - flags read-only to processor
module ppih_top (
  input wire logic clk,                  // 10 mhz bus clock
  input wire logic reset,                // async reset, active high
  input wire ppih_pkg::ppih_bus_s bus,   // processor access
  output logic [7:0] rdata,              // read data, registered
  input wire logic [7:0] port_a_lines_i, // port a pin levels
  output ppih_pkg::ppih_pins_s port_a_lines, // port a drive
  input wire logic [7:0] port_b_lines_i, // port b pin levels
  output ppih_pkg::ppih_pins_s port_b_lines, // port b drive
  input wire logic side_a_edge_in,       // a edge input
  input wire logic side_a_ctl_line_i,    // a control line level
  output logic side_a_ctl_line_o,        // a control line drive
  output logic side_a_ctl_line_oe,       // a control line enable
  input wire logic side_b_edge_in,       // b edge input
  input wire logic side_b_ctl_line_i,    // b control line level
  output logic side_b_ctl_line_o,        // b control line drive
  output logic side_b_ctl_line_oe,       // b control line enable
  output logic side_a_irq_n,             // a irq, active low
  output logic side_b_irq_n              // b irq, active low
);
  logic [7:0] port_a_output_reg_ff;  // a output data
  logic [7:0] port_b_output_reg_ff;  // b output data
  logic [7:0] dir_a_ff;              // a direction
  logic [7:0] dir_b_ff;              // b direction
  logic [7:0] rdata_ff;              // read data
  logic [7:0] side_a_ctrl_reg;       // a control view
  logic [7:0] side_b_ctrl_reg;       // b control view
  logic [7:0] nxt_rdata;             // read mux
  logic a_sel_data;                  // a data location selected
  logic b_sel_data;                  // b data location selected
  logic a_data_rd;                   // read a data
  logic b_data_rd;                   // read b data
  logic b_data_wr;                   // write b data

  assign a_sel_data = side_a_ctrl_reg[ppih_pkg::CTL_DATA_SEL];
  assign b_sel_data = side_b_ctrl_reg[ppih_pkg::CTL_DATA_SEL];
  assign a_data_rd = bus.rd && bus.sel == ppih_pkg::SEL_A_DATA && a_sel_data;
  assign b_data_rd = bus.rd && bus.sel == ppih_pkg::SEL_B_DATA && b_sel_data;
  assign b_data_wr = bus.wr && bus.sel == ppih_pkg::SEL_B_DATA && b_sel_data;

  ppih_side #(.SIDE_B(1'b0)) u_side_a (
    .clk(clk), .reset(reset),
    .ctl_wr(bus.wr && bus.sel == ppih_pkg::SEL_A_CTRL), .wdata(bus.wdata),
    .data_rd(a_data_rd), .data_wr(1'b0),
    .edge_pin(side_a_edge_in), .line_pin(side_a_ctl_line_i),
    .ctrl(side_a_ctrl_reg), .line_o(side_a_ctl_line_o),
    .line_oe(side_a_ctl_line_oe), .irq_n(side_a_irq_n));

  ppih_side #(.SIDE_B(1'b1)) u_side_b (
    .clk(clk), .reset(reset),
    .ctl_wr(bus.wr && bus.sel == ppih_pkg::SEL_B_CTRL), .wdata(bus.wdata),
    .data_rd(b_data_rd), .data_wr(b_data_wr),
    .edge_pin(side_b_edge_in), .line_pin(side_b_ctl_line_i),
    .ctrl(side_b_ctrl_reg), .line_o(side_b_ctl_line_o),
    .line_oe(side_b_ctl_line_oe), .irq_n(side_b_irq_n));

  // data and direction register writes, routed by control bit 2
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      port_a_output_reg_ff <= ppih_pkg::DATA_RESET;
      port_b_output_reg_ff <= ppih_pkg::DATA_RESET;
      dir_a_ff <= ppih_pkg::DATA_RESET;
      dir_b_ff <= ppih_pkg::DATA_RESET;
    end else if (bus.wr) begin
      case (bus.sel)
        ppih_pkg::SEL_A_DATA: begin
          if (a_sel_data) port_a_output_reg_ff <= bus.wdata;
          else dir_a_ff <= bus.wdata;
        end
        ppih_pkg::SEL_B_DATA: begin
          if (b_sel_data) port_b_output_reg_ff <= bus.wdata;
          else dir_b_ff <= bus.wdata;
        end
        default: ;
      endcase
    end
  end

  // read mux: a reads pins, b reads output reg for output lines
  always_comb begin
    case (bus.sel)
      ppih_pkg::SEL_A_DATA: nxt_rdata = a_sel_data ? port_a_lines_i : dir_a_ff;
      ppih_pkg::SEL_A_CTRL: nxt_rdata = side_a_ctrl_reg;
      ppih_pkg::SEL_B_DATA: nxt_rdata = b_sel_data ?
        ((port_b_output_reg_ff & dir_b_ff) | (port_b_lines_i & ~dir_b_ff)) : dir_b_ff;
      ppih_pkg::SEL_B_CTRL: nxt_rdata = side_b_ctrl_reg;
      default: nxt_rdata = 8'h00;
    endcase
  end

  // capture read data on a read strobe
  always_ff @(posedge clk or posedge reset) begin
    if (reset) rdata_ff <= 8'h00;
    else if (bus.rd) rdata_ff <= nxt_rdata;
  end
  assign rdata = rdata_ff;

  // port drive: enable per direction bit (see RQ5, RQ6)
  assign port_a_lines.o = port_a_output_reg_ff;
  assign port_a_lines.oe = dir_a_ff;
  assign port_b_lines.o = port_b_output_reg_ff;
  assign port_b_lines.oe = dir_b_ff;
endmodule : ppih_top

// ### ppih_pkg.sv
// package for the parallel port adapter: control bit positions, register selects, carriers
// assumes nothing beyond a systemverilog compiler
package ppih_pkg;
  localparam int unsigned CTL_EN_EDGE = 0;      // edge input irq enable
  localparam int unsigned CTL_EDGE_POL = 1;     // edge input polarity, 1 rising
  localparam int unsigned CTL_DATA_SEL = 2;     // 1 data location, 0 direction reg
  localparam int unsigned CTL_EN_LINE = 3;      // control line irq enable / output level
  localparam int unsigned CTL_LINE_POL = 4;     // control line polarity / manual select
  localparam int unsigned CTL_LINE_OUT = 5;     // control line is output
  localparam int unsigned CTL_FLAG_LINE = 6;    // control line flag
  localparam int unsigned CTL_FLAG_EDGE = 7;    // edge input flag
  localparam logic [7:0] CTL_RESET = 8'h00;     // control register after reset
  localparam logic [7:0] CTL_WR_MASK = 8'h3F;   // writable control bits
  localparam logic [7:0] DATA_RESET = 8'h00;    // data and direction after reset
  localparam logic [1:0] SEL_A_DATA = 2'h0;     // port a data or direction
  localparam logic [1:0] SEL_A_CTRL = 2'h1;     // port a control
  localparam logic [1:0] SEL_B_DATA = 2'h2;     // port b data or direction
  localparam logic [1:0] SEL_B_CTRL = 2'h3;     // port b control
  localparam int unsigned SYNC_STAGES = 2;      // synchroniser depth

  // processor access request
  typedef struct packed {
    logic       rd;     // read strobe
    logic       wr;     // write strobe
    logic [1:0] sel;    // register select
    logic [7:0] wdata;  // write data
  } ppih_bus_s;

  // two-signal pin group
  typedef struct packed {
    logic [7:0] o;      // output level
    logic [7:0] oe;     // output enable
  } ppih_pins_s;

  // control line output mode
  typedef enum logic [1:0] {
    LINE_INPUT = 2'b00,
    LINE_HSHAKE = 2'b01,
    LINE_PULSE = 2'b10,
    LINE_MANUAL = 2'b11
  } ppih_line_e;
endpackage : ppih_pkg

// ### ppih_edge.sv
// synchroniser plus edge detector for one control input
// assumes the input is asynchronous to clk
module ppih_edge (
  input wire logic clk,     // bus clock
  input wire logic reset,   // async reset, active high
  input wire logic din,     // raw pin level
  input wire logic rising,  // 1 selects rising edge
  output logic level,       // synchronised level
  output logic active       // one-cycle active edge pulse
);
  logic [ppih_pkg::SYNC_STAGES-1:0] sync_ff; // two-stage synchroniser
  logic prev_ff;                             // previous synchronised sample

  // synchronise, then keep one older sample
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sync_ff <= '0;
      prev_ff <= 1'b0;
    end else begin
      sync_ff <= {sync_ff[0], din};
      prev_ff <= sync_ff[1];
    end
  end

  assign level = sync_ff[1];
  // compare successive registered samples (see RQ22)
  assign active = rising ? (sync_ff[1] & ~prev_ff) : (~sync_ff[1] & prev_ff);
endmodule : ppih_edge

// ### ppih_side.sv
// one side's control register, flags, control line and irq
// assumes access strobes are one-cycle pulses from the top
module ppih_side #(
  parameter bit SIDE_B = 1'b0   // 0 read handshake (a), 1 write handshake (b)
) (
  input wire logic clk,          // bus clock
  input wire logic reset,        // async reset, active high
  input wire logic ctl_wr,       // control register write
  input wire logic [7:0] wdata,  // write data
  input wire logic data_rd,      // data location read
  input wire logic data_wr,      // data location write
  input wire logic edge_pin,     // edge input pin
  input wire logic line_pin,     // control line pin in
  output logic [7:0] ctrl,       // control register view
  output logic line_o,           // control line drive level
  output logic line_oe,          // control line drive enable
  output logic irq_n             // interrupt request, active low
);
  logic [5:0] cfg_ff;            // writable control bits
  logic flag_edge_ff;            // bit 7 flag
  logic flag_line_ff;            // bit 6 flag
  logic line_ff;                 // control line output
  logic line_oe_ff;              // control line enable
  logic irq_n_ff;                // registered irq
  logic edge_act;                // active edge on edge input
  logic line_act;                // active edge on control line
  logic access;                  // the triggering data access
  ppih_pkg::ppih_line_e mode;    // control line mode

  ppih_edge u_edge (.clk(clk), .reset(reset), .din(edge_pin),
    .rising(cfg_ff[ppih_pkg::CTL_EDGE_POL]), .level(), .active(edge_act));
  ppih_edge u_line (.clk(clk), .reset(reset), .din(line_pin),
    .rising(cfg_ff[ppih_pkg::CTL_LINE_POL]), .level(), .active(line_act));

  // decode mode from bits 5..3
  always_comb begin
    if (!cfg_ff[ppih_pkg::CTL_LINE_OUT]) mode = ppih_pkg::LINE_INPUT;
    else if (cfg_ff[ppih_pkg::CTL_LINE_POL]) mode = ppih_pkg::LINE_MANUAL;
    else if (cfg_ff[ppih_pkg::CTL_EN_LINE]) mode = ppih_pkg::LINE_PULSE;
    else mode = ppih_pkg::LINE_HSHAKE;
  end
  assign access = SIDE_B ? data_wr : data_rd; // see RQ18

  // writable bits only; flags not touched by writes (see RQ23)
  always_ff @(posedge clk or posedge reset) begin
    if (reset) cfg_ff <= ppih_pkg::CTL_RESET[5:0];
    else if (ctl_wr) cfg_ff <= wdata[5:0];
  end

  // edge flag: set regardless of enable, set beats clear (see RQ1, RQ7, RQ8, RQ16)
  always_ff @(posedge clk or posedge reset) begin
    if (reset) flag_edge_ff <= 1'b0;
    else if (edge_act) flag_edge_ff <= 1'b1;
    else if (data_rd) flag_edge_ff <= 1'b0; // see RQ2, RQ21
  end

  // line flag only in input mode (see RQ9, RQ10, RQ17)
  always_ff @(posedge clk or posedge reset) begin
    if (reset) flag_line_ff <= 1'b0;
    else if (line_act && mode == ppih_pkg::LINE_INPUT) flag_line_ff <= 1'b1;
    else if (data_rd) flag_line_ff <= 1'b0; // see RQ2, RQ21
  end

  // control line output behaviour
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      line_ff <= 1'b1;
      line_oe_ff <= 1'b0;
    end else begin
      line_oe_ff <= (mode != ppih_pkg::LINE_INPUT);
      case (mode)
        ppih_pkg::LINE_INPUT: line_ff <= 1'b1;
        ppih_pkg::LINE_HSHAKE: begin
          if (access) line_ff <= 1'b0;          // see RQ13, RQ20
          else if (edge_act) line_ff <= 1'b1;   // see RQ14, RQ19, RQ20
        end
        ppih_pkg::LINE_PULSE: line_ff <= ~access; // low one cycle (see RQ11, RQ12)
        ppih_pkg::LINE_MANUAL: line_ff <= cfg_ff[ppih_pkg::CTL_EN_LINE]; // see RQ15
        default: line_ff <= 1'b1;
      endcase
    end
  end

  // irq low on enabled flag (see RQ3, RQ4)
  always_ff @(posedge clk or posedge reset) begin
    if (reset) irq_n_ff <= 1'b1;
    else irq_n_ff <= ~((flag_edge_ff & cfg_ff[ppih_pkg::CTL_EN_EDGE]) |
                       (flag_line_ff & cfg_ff[ppih_pkg::CTL_EN_LINE]));
  end

  assign ctrl = {flag_edge_ff, flag_line_ff, cfg_ff};
  assign line_o = line_ff;
  assign line_oe = line_oe_ff;
  assign irq_n = irq_n_ff;
endmodule : ppih_side

// ### ppih_periph.sv
// peripheral model: port and control pin wires, handshake acknowledge
// assumes the adapter's drive outputs and the bus clock
module ppih_periph (
  input wire logic clk, // bus clock
  input wire logic reset, // async reset
  input wire logic [3:0] dly, // ack delay, 0 none
  input wire logic [3:0] lvl, // idle eb lb ea la
  input wire logic [15:0] pd, // data offered b a
  input wire ppih_pkg::ppih_pins_s pa_p, // a drive
  input wire ppih_pkg::ppih_pins_s pb_p, // b drive
  input wire logic [1:0] ln_o, // line drive b a
  input wire logic [1:0] ln_oe, // line enable b a
  output logic [7:0] pa_i, // a wire
  output logic [7:0] pb_i, // b wire
  output logic [1:0] ln_i, // line wire b a
  output logic [1:0] ed // edge inputs b a
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0][3:0] cnt_ff; // wait since line fell
  logic [1:0] ack_ff; // ack pulse
  // a driver wins, else the peripheral
  assign pa_i = (pa_p.oe & pa_p.o) | (~pa_p.oe & pd[7:0]);
  assign pb_i = (pb_p.oe & pb_p.o) | (~pb_p.oe & pd[15:8]);
  assign ln_i = (ln_oe & ln_o) | (~ln_oe & {lvl[2], lvl[0]});
  assign ed = {lvl[3], lvl[1]} ^ ack_ff;
  // acknowledge a low line after dly cycles
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cnt_ff <= '0;
      ack_ff <= 2'b00;
    end else begin
      for (int s = 0; s < 2; s++) begin
        ack_ff[s] <= 1'b0;
        if (!ln_oe[s] || ln_o[s]) cnt_ff[s] <= 4'h0; // line high
        else if (cnt_ff[s] != dly) cnt_ff[s] <= cnt_ff[s] + 4'h1;
        else ack_ff[s] <= dly != 4'h0;
      end
    end
  end
endmodule : ppih_periph

// ### ppih_chk.sv
// checker for control lines and irq outputs
// assumes bound to ppih_top; control bits shadowed from writes
module ppih_chk (
  input wire logic clk, // bus clock
  input wire logic reset, // async reset
  input wire ppih_pkg::ppih_bus_s bus, // access
  input wire logic side_a_ctl_line_o, // a line
  input wire logic side_b_ctl_line_o, // b line
  input wire logic side_a_irq_n, // a irq
  input wire logic side_b_irq_n // b irq
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [5:0] ca_ff; // a control shadow
  logic [5:0] cb_ff; // b control shadow
  logic rda; // a data read
  logic wrb; // b data write
  logic rdb; // b data read
  // shadow the writable control bits
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ca_ff <= 6'h00;
      cb_ff <= 6'h00;
    end else begin
      if (bus.wr && bus.sel == ppih_pkg::SEL_A_CTRL) ca_ff <= bus.wdata[5:0];
      if (bus.wr && bus.sel == ppih_pkg::SEL_B_CTRL) cb_ff <= bus.wdata[5:0];
    end
  end
  assign rda = bus.rd && bus.sel == ppih_pkg::SEL_A_DATA && ca_ff[2];
  assign wrb = bus.wr && bus.sel == ppih_pkg::SEL_B_DATA && cb_ff[2];
  assign rdb = bus.rd && bus.sel == ppih_pkg::SEL_B_DATA && cb_ff[2];
  default clocking dclk @(posedge clk); endclocking
  default disable iff (reset);
  sequence s_low_a; !side_a_ctl_line_o ##1 side_a_ctl_line_o; endsequence
  sequence s_low_b; !side_b_ctl_line_o ##1 side_b_ctl_line_o; endsequence
  property p_pulse_a; rda && ca_ff[5:3] == 3'b101 |=> s_low_a; endproperty
  a_pulse_a: assert property (p_pulse_a) else $error("a pulse bad");
  property p_pulse_b; wrb && cb_ff[5:3] == 3'b101 |=> s_low_b; endproperty
  a_pulse_b: assert property (p_pulse_b) else $error("b pulse bad");
  property p_hs_a; rda && ca_ff[5:3] == 3'b100 |=> !side_a_ctl_line_o; endproperty
  a_hs_a: assert property (p_hs_a) else $error("a line not low");
  property p_hs_b; wrb && cb_ff[5:3] == 3'b100 |=> !side_b_ctl_line_o; endproperty
  a_hs_b: assert property (p_hs_b) else $error("b line not low");
  property p_man_a; $stable(ca_ff) && ca_ff[5:4] == 2'b11 |-> side_a_ctl_line_o == ca_ff[3]; endproperty
  a_man_a: assert property (p_man_a) else $error("a manual bad");
  property p_clr_a; rda |-> ##2 side_a_irq_n; endproperty
  a_clr_a: assert property (p_clr_a) else $error("a irq kept");
  property p_clr_b; rdb |-> ##2 side_b_irq_n; endproperty
  a_clr_b: assert property (p_clr_b) else $error("b irq kept");
  // irq register uses the enables of the cycle before it fell
  property p_irq_b; $fell(side_b_irq_n) |-> $past(cb_ff[0]) || $past(cb_ff[3]); endproperty
  a_irq_b: assert property (p_irq_b) else $error("b irq unenabled");
endmodule : ppih_chk
bind ppih_top ppih_chk u_chk (.clk(clk), .reset(reset), .bus(bus),
  .side_a_ctl_line_o(side_a_ctl_line_o), .side_b_ctl_line_o(side_b_ctl_line_o),
  .side_a_irq_n(side_a_irq_n), .side_b_irq_n(side_b_irq_n));

// ### ppih_top_tb.sv
// testbench for the dual parallel port adapter
// assumes ppih_top, ppih_periph and ppih_chk compiled first
module ppih_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk; // bus clock
  logic reset; // async reset
  ppih_pkg::ppih_bus_s bus; // access
  logic [7:0] rdata; // read data
  ppih_pkg::ppih_pins_s pa_p, pb_p; // port drives
  logic [7:0] pa_i, pb_i; // port wires
  wire [1:0] ln_o, ln_oe, irq_n; // per side b a, driven bit by bit
  logic [1:0] ln_i, ed; // per side b a
  logic [3:0] dly, lvl; // peripheral ack delay, idle levels
  logic [15:0] pd; // peripheral data b a
  int failures, check_count; // tallies
  ppih_top u_dut (.clk(clk), .reset(reset), .bus(bus), .rdata(rdata),
    .port_a_lines_i(pa_i), .port_a_lines(pa_p), .port_b_lines_i(pb_i), .port_b_lines(pb_p),
    .side_a_edge_in(ed[0]), .side_a_ctl_line_i(ln_i[0]), .side_a_ctl_line_o(ln_o[0]),
    .side_a_ctl_line_oe(ln_oe[0]), .side_b_edge_in(ed[1]), .side_b_ctl_line_i(ln_i[1]),
    .side_b_ctl_line_o(ln_o[1]), .side_b_ctl_line_oe(ln_oe[1]),
    .side_a_irq_n(irq_n[0]), .side_b_irq_n(irq_n[1]));
  ppih_periph u_per (.clk(clk), .reset(reset), .dly(dly), .lvl(lvl), .pd(pd),
    .pa_p(pa_p), .pb_p(pb_p), .ln_o(ln_o), .ln_oe(ln_oe),
    .pa_i(pa_i), .pb_i(pb_i), .ln_i(ln_i), .ed(ed));
  // clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // compare and tally
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // one bus write, ends mid cycle
  task automatic wr(input logic [1:0] s, input logic [7:0] d);
    @(posedge clk);
    bus <= {1'b0, 1'b1, s, d};
    @(posedge clk);
    bus.wr <= 1'b0;
    @(negedge clk);
  endtask : wr
  // one bus read
  task automatic rd(input logic [1:0] s, output logic [7:0] q);
    @(posedge clk);
    bus <= {1'b1, 1'b0, s, 8'h00};
    @(posedge clk);
    bus.rd <= 1'b0;
    @(negedge clk);
    q = rdata;
  endtask : rd
  // the access that drives a side's line: a read, b write after a flag-clearing read
  task automatic acc(input int s);
    logic [7:0] q;
    if (s) begin
      rd(2'h2, q); // clear b flags so irq is seen to fall again
      wr(2'h2, 8'h5A);
    end else rd(2'h0, q);
  endtask : acc
  // reset values, direction and port data
  task automatic t_dir;
    logic [7:0] q;
    chk({irq_n, ln_oe, ln_o, 2'b00}, 8'hCC);
    chk(pa_p.oe | pb_p.oe, 8'h00);
    wr(2'h0, 8'hF0);
    wr(2'h2, 8'h0F);
    wr(2'h1, 8'h04);
    wr(2'h3, 8'h04);
    wr(2'h0, 8'hA5);
    wr(2'h2, 8'h3C);
    chk(pa_p.oe, 8'hF0);
    chk(pb_p.oe, 8'h0F);
    chk(pa_p.o, 8'hA5);
    chk(pb_p.o, 8'h3C);
    rd(2'h0, q);
    chk(q, 8'hA6);
    rd(2'h2, q);
    chk(q, 8'h9C);
  endtask : t_dir
  // one flag source: k 0 edge input, 1 control line
  task automatic t_flag(input int s, input int k, input bit pol, input bit en);
    logic [7:0] cv, q;
    int i;
    cv = k ? {3'b000, pol, en, 3'b100} : {6'b000001, pol, en};
    i = 2 * s + 1 - k;
    @(posedge clk);
    lvl[i] <= !pol;
    repeat (6) @(negedge clk);
    wr(2'(2 * s + 1), cv | 8'hC0);
    rd(2'(2 * s), q);
    rd(2'(2 * s + 1), q);
    chk(q, cv);
    @(posedge clk);
    lvl[i] <= pol;
    repeat (6) @(negedge clk);
    rd(2'(2 * s + 1), q);
    chk(q, cv | (k ? 8'h40 : 8'h80));
    chk(8'(irq_n[s]), 8'(!en));
    rd(2'(2 * s), q);
    repeat (2) @(negedge clk);
    chk(8'(irq_n[s]), 8'h01);
  endtask : t_flag
  // output modes of one side's control line
  task automatic t_out(input int s);
    logic [1:0] cs;
    cs = 2'(2 * s + 1);
    wr(cs, 8'h2C);
    @(negedge clk); // line drive follows the new mode one cycle later
    chk(8'({ln_oe[s], ln_o[s]}), 8'h03);
    acc(s);
    chk(8'(ln_o[s]), 8'h00);
    @(negedge clk);
    chk(8'(ln_o[s]), 8'h01);
    for (int v = 0; v < 2; v++) begin
      wr(cs, v ? 8'h3C : 8'h34);
      repeat (2) @(negedge clk);
      chk(8'(ln_o[s]), 8'(v));
    end
    // prompt then slow peripheral
    for (int d = 1; d < 9; d += 7) begin
      wr(cs, 8'h25);
      acc(s);
      chk(8'(ln_o[s]), 8'h00);
      @(posedge clk);
      dly <= 4'(d);
      for (int n = 0; n < 30 && ln_o[s] !== 1'b1; n++) @(negedge clk);
      chk(8'(ln_o[s]), 8'h01);
      @(posedge clk);
      dly <= 4'h0;
      repeat (2) @(negedge clk);
      chk(8'(irq_n[s]), 8'h00);
    end
  endtask : t_out
  // verdict and stop
  task automatic end_sim;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : end_sim
  // main sequence
  initial begin
    {bus, dly, lvl, pd} = {12'h000, 4'h0, 4'hF, 16'h9966};
    reset = 1'b1;
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    @(negedge clk);
    t_dir();
    for (int m = 0; m < 16; m++) t_flag(m / 8, (m / 4) % 2, m[1], m[0]);
    t_out(0);
    t_out(1);
    end_sim();
  end
  // watchdog
  initial begin
    #1_000_000;
    failures++;
    end_sim();
  end
endmodule : ppih_top_tb
